// ---- rtl/daq_defs.svh ----
// Register offsets, field positions and fixed codes of the paged register bank
// Notes on behaviour
// - Hold-off bit set discards later page-register writes
// - Reset bit reinitialises the whole acquisition logic
// - Page bits select page at offsets 1-31
// - Offsets 24-26 hold 24-bit pulse load value
// - Command mode loads period or duty counter
// - Config bit 3 picks fast or 100 kHz clock
// - Config bit 2 sets output active level
// - Calibration data forwarded; read byte valid after busy
// - Storage read/write; trim converters write only
// - Storage uses eight address bits, trim three
// - Storage enable starts transfer, direction bit chosen
// - Trim enable starts transfer, overriding storage enable
// - Reload copies storage 0-7 into trims, busy
// - Reference mux bit routes references, reads back
// - Status shows trim and storage busy bits
// - Storage enable needs key 0xA5 first; reload does not
// - Offset 31 reads design revision code
// - ID page gives input count, depth, outputs
// - ID page gives pin count and pulse/timer counts
// - Offsets 28-29 give 16-bit chip identifier
// - Page 3 returns 31 fixed text bytes
`ifndef DAQ_DEFS_SVH
`define DAQ_DEFS_SVH
`define OFS_PAGE        5'h00
`define OFS_LOAD_LO     5'h18
`define OFS_LOAD_MID    5'h19
`define OFS_LOAD_HI     5'h1A
`define OFS_PCMD        5'h1B
`define OFS_CAL_DATA    5'h1C
`define OFS_CAL_ADDR    5'h1D
`define OFS_CAL_CTRL    5'h1E
`define OFS_KEY         5'h1F
`define PG_MAIN         2'h0
`define PG_EXT          2'h1
`define PG_ID           2'h2
`define PG_TEXT         2'h3
`define B_WRITE_IGNORE_LATCH       7
`define B_RESET         6
`define B_FLAG          7
`define B_CLK           3
`define B_POL           2
`define B_PULSE_OUTPUT_ON         1
`define B_ENA           0
`define B_STORAGE_TRANSFER_GO         7
`define B_STORAGE_DIRECTION         6
`define B_RELOAD        5
`define B_MUX           4
`define B_TD_EN         3
`define STORAGE_KEY     8'hA5
`define ANALOG_CFG_RST  8'h04
`define FIFO_THR_RST    11'h400
`define REV_CODE        8'h3C // Arbitrary value
`define ID_COUNT_IN     8'h20
`define ID_DEPTH        3'h1
`define ID_COUNT_OUT    5'h04
`define ID_COUNT_PIN    8'h28
`define ID_PWM_CTR      8'h42
`define CHIP_ID         16'h9A5C // Arbitrary value, top bit marks released
`define CHIP_ID_LO      8'h5C
`define CHIP_ID_HI      8'h9A
`define TRIM_LAST       3'h7
`define BIT_TIME_NS     1000
`define CLK_NS          50
`define BIT_CYC         ((`BIT_TIME_NS + `CLK_NS - 1) / `CLK_NS)
`endif

// ---- rtl/daq_pkg.sv ----
// Types shared by the register bank, its checker and its testbench
package daq_pkg;
   typedef enum logic [3:0] {
      S_IDLE = 4'b0001,
      S_SHIFT = 4'b0010,
      S_DONE = 4'b0100,
      S_NEXT = 4'b1000
   } cal_state_t;
   typedef logic [7:0] byte_t;
endpackage : daq_pkg

// ---- rtl/cal_serial.sv ----
// Serial shifter that clocks one calibration frame out and one byte in
`include "daq_defs.svh"
module cal_serial (
   input  wire logic         ref_clk,
   input  wire logic         nrst,
   input  wire logic         clk_en,
   input  wire logic         start,
   input  wire logic [17:0]  frame,
   input  wire logic         sdi,
   output logic              busy,
   output logic              done,
   output logic              sclk,
   output logic              sdo,
   output logic [7:0]        rx
);
   localparam logic [5:0] BIT_CYC = 6'(`BIT_CYC);
   logic [5:0]  div_q, div_d;
   logic [4:0]  cnt_q, cnt_d;
   logic [17:0] sh_q, sh_d;
   logic [7:0]  rx_q, rx_d;
   logic        busy_q, busy_d, done_q, done_d, sclk_q, sclk_d;
   always_comb begin
      div_d = div_q;
      cnt_d = cnt_q;
      sh_d = sh_q;
      rx_d = rx_q;
      busy_d = busy_q;
      done_d = 1'b0;
      sclk_d = sclk_q;
      if (!busy_q) begin
         if (start) begin
            sh_d = frame;
            cnt_d = 5'h12;
            div_d = 6'h00;
            busy_d = 1'b1;
            sclk_d = 1'b0;
         end
      end else if (div_q == BIT_CYC - 6'h01) begin
         div_d = 6'h00;
         sclk_d = ~sclk_q;
         // Sample on rising half, shift on falling half
         if (!sclk_q) begin
            rx_d = {rx_q[6:0], sdi};
         end else begin
            sh_d = {sh_q[16:0], 1'b0};
            cnt_d = cnt_q - 5'h01;
            if (cnt_q == 5'h01) begin
               busy_d = 1'b0;
               done_d = 1'b1;
            end
         end
      end else begin
         div_d = div_q + 6'h01;
      end
   end
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         div_q <= 6'h00;
         cnt_q <= 5'h00;
         sh_q <= 18'h00000;
         rx_q <= 8'h00;
         busy_q <= 1'b0;
         done_q <= 1'b0;
         sclk_q <= 1'b0;
      end else if (clk_en) begin
         div_q <= div_d;
         cnt_q <= cnt_d;
         sh_q <= sh_d;
         rx_q <= rx_d;
         busy_q <= busy_d;
         done_q <= done_d;
         sclk_q <= sclk_d;
      end
   end
   assign busy = busy_q;
   assign done = done_q;
   assign sclk = sclk_q;
   assign sdo = sh_q[17];
   assign rx = rx_q;
endmodule : cal_serial

// ---- rtl/daq_ext_pages.sv ----
// Paged register bank: page select, pulse and calibration page, ID and text pages
`include "daq_defs.svh"
module daq_ext_pages (
   input  wire logic          ref_clk,
   input  wire logic          nrst,
   input  wire logic          clk_en,
   input  wire logic [4:0]    addr,
   input  wire logic [7:0]    wdata,
   input  wire logic          wr_n,
   input  wire logic          rd_n,
   input  wire logic          cs_n,
   output logic [7:0]         rdata,
   input  wire logic          cal_sdi,
   output logic               cal_sclk,
   output logic               cal_sdo,
   output logic               storage_sel_n,
   output logic               trim_sel_n,
   output logic               acq_reset,
   output logic [1:0]         page,
   output logic [23:0]        pulse_load_value,
   output logic [1:0]         pulse_sel,
   output logic               pulse_load_period,
   output logic               pulse_load_duty,
   output logic               pulse_slow_clk,
   output logic [3:0]         pulse_active_level,
   output logic [3:0]         pulse_output_on,
   output logic [3:0]         pulse_run,
   output logic               reference_mux_on,
   output daq_pkg::byte_t     analog_cfg_init,
   output logic [10:0]        fifo_thr_init
);
   import daq_pkg::*;
   ////////////////////////////////////////////////////////////////////////////
   // Host strobe sync: pins cross from the ISA side through three stages
   logic [2:0] wr_s_q, rd_s_q, cs_s_q;
   logic       wr_ev_q, rd_ev_q;
   logic       wr_lvl, rd_lvl;
   logic       wr_go, rd_go;
   logic [1:0] page_q, page_d;
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         wr_s_q <= 3'h7;
         rd_s_q <= 3'h7;
         cs_s_q <= 3'h7;
         wr_ev_q <= 1'b0;
         rd_ev_q <= 1'b0;
      end else if (clk_en) begin
         wr_s_q <= {wr_s_q[1:0], wr_n};
         rd_s_q <= {rd_s_q[1:0], rd_n};
         cs_s_q <= {cs_s_q[1:0], cs_n};
         wr_ev_q <= wr_lvl;
         rd_ev_q <= rd_lvl;
      end
   end
   // Act once the second and third stages agree on an asserted strobe
   assign wr_lvl = !wr_s_q[1] && !wr_s_q[2] && !cs_s_q[1] && !cs_s_q[2];
   assign rd_lvl = !rd_s_q[1] && !rd_s_q[2] && !cs_s_q[1] && !cs_s_q[2];
   // Level remembered so a long strobe acts only once
   assign wr_go = wr_lvl && !wr_ev_q;
   assign rd_go = rd_lvl && !rd_ev_q;
   // Address and data are stable for the whole strobe, so sampling them is safe
   logic wr_page, wr_ext;
   assign wr_page = wr_go && (addr == `OFS_PAGE);
   assign wr_ext = wr_go && (page_q == `PG_EXT);
   ////////////////////////////////////////////////////////////////////////////
   // Page, reset and pulse registers
   logic        hold_q, hold_d, arst_q, arst_d;
   logic [23:0] load_q, load_d;
   logic [1:0]  psel_q, psel_d;
   logic        lp_q, lp_d, ld_q, ld_d, slow_q, slow_d;
   logic [3:0]  pol_q, pol_d, oen_q, oen_d, run_q, run_d;
   always_comb begin
      page_d = page_q;
      hold_d = hold_q;
      arst_d = 1'b0;
      load_d = load_q;
      psel_d = psel_q;
      lp_d = 1'b0;
      ld_d = 1'b0;
      slow_d = slow_q;
      pol_d = pol_q;
      oen_d = oen_q;
      run_d = run_q;
      if (wr_page && !hold_q) begin
         hold_d = wdata[`B_WRITE_IGNORE_LATCH];
         page_d = wdata[1:0];
         arst_d = wdata[`B_RESET];
      end
      if (wr_ext) begin
         case (addr)
            `OFS_LOAD_LO: load_d[7:0] = wdata;
            `OFS_LOAD_MID: load_d[15:8] = wdata;
            `OFS_LOAD_HI: load_d[23:16] = wdata;
            `OFS_PCMD: begin
               psel_d = wdata[5:4];
               if (!wdata[`B_FLAG]) begin
                  // Nonzero bits 1-3 are not a load command
                  if (wdata[3:1] == 3'h0) begin
                     lp_d = !wdata[`B_ENA];
                     ld_d = wdata[`B_ENA];
                  end
               end else begin
                  slow_d = wdata[`B_CLK];
                  pol_d[wdata[5:4]] = wdata[`B_POL];
                  oen_d[wdata[5:4]] = wdata[`B_PULSE_OUTPUT_ON];
                  // Gated here so the run output stays a bare flop
                  run_d[wdata[5:4]] = wdata[`B_ENA] && wdata[`B_PULSE_OUTPUT_ON];
               end
            end
            default: ;
         endcase
      end
   end
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         page_q <= `PG_MAIN;
         hold_q <= 1'b0;
         arst_q <= 1'b0;
         load_q <= 24'h000000;
         psel_q <= 2'h0;
         lp_q <= 1'b0;
         ld_q <= 1'b0;
         slow_q <= 1'b0;
         pol_q <= 4'h0;
         oen_q <= 4'h0;
         run_q <= 4'h0;
      end else if (clk_en) begin
         page_q <= page_d;
         hold_q <= hold_d;
         arst_q <= arst_d;
         load_q <= load_d;
         psel_q <= psel_d;
         lp_q <= lp_d;
         ld_q <= ld_d;
         slow_q <= slow_d;
         pol_q <= pol_d;
         oen_q <= oen_d;
         run_q <= run_d;
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // Calibration storage and trim converter engine
   cal_state_t  st_q, st_d;
   logic [7:0]  cdat_q, cdat_d, cadr_q, cadr_d;
   logic        key_q, key_d, mux_q, mux_d, rd_dir_q, rd_dir_d;
   logic        trim_q, trim_d, reload_q, reload_d, eesel_q, eesel_d, tdsel_q, tdsel_d;
   logic [2:0]  ridx_q, ridx_d;
   logic        go_d, go_q;
   logic [17:0] frame_d, frame_q;
   logic        ser_busy, ser_done;
   logic [7:0]  ser_rx;
   always_comb begin
      st_d = st_q;
      cdat_d = cdat_q;
      cadr_d = cadr_q;
      key_d = key_q;
      mux_d = mux_q;
      rd_dir_d = rd_dir_q;
      trim_d = trim_q;
      reload_d = reload_q;
      eesel_d = eesel_q;
      tdsel_d = tdsel_q;
      ridx_d = ridx_q;
      go_d = 1'b0;
      frame_d = frame_q;
      // Writes while busy are the host's fault; dropped to protect the frame
      if (wr_ext && st_q == S_IDLE) begin
         case (addr)
            `OFS_CAL_DATA: cdat_d = wdata;
            `OFS_CAL_ADDR: cadr_d = wdata;
            `OFS_KEY: key_d = (wdata == `STORAGE_KEY);
            `OFS_CAL_CTRL: begin
               mux_d = wdata[`B_MUX];
               if (wdata[`B_TD_EN]) begin
                  trim_d = 1'b1;
                  tdsel_d = 1'b1;
                  rd_dir_d = 1'b0;
                  frame_d = {1'b0, 1'b0, 5'h00, cadr_q[2:0], cdat_q};
                  go_d = 1'b1;
                  st_d = S_SHIFT;
               end else if (wdata[`B_RELOAD]) begin
                  reload_d = 1'b1;
                  ridx_d = 3'h0;
                  rd_dir_d = 1'b1;
                  eesel_d = 1'b1;
                  frame_d = {1'b1, 1'b1, 8'h00, 8'h00};
                  go_d = 1'b1;
                  st_d = S_SHIFT;
               end else if (wdata[`B_STORAGE_TRANSFER_GO] && key_q) begin
                  key_d = 1'b0;
                  rd_dir_d = wdata[`B_STORAGE_DIRECTION];
                  eesel_d = 1'b1;
                  frame_d = {1'b1, wdata[`B_STORAGE_DIRECTION], cadr_q, cdat_q};
                  go_d = 1'b1;
                  st_d = S_SHIFT;
               end
            end
            default: ;
         endcase
      end
      case (st_q)
         S_IDLE: ;
         S_SHIFT: begin
            if (ser_done) begin
               st_d = S_DONE;
            end
         end
         S_DONE: begin
            eesel_d = 1'b0;
            tdsel_d = 1'b0;
            if (rd_dir_q && !reload_q) begin
               cdat_d = ser_rx;
            end
            if (reload_q && rd_dir_q) begin
               // Storage byte fetched, now write it into the trim at same index
               rd_dir_d = 1'b0;
               tdsel_d = 1'b1;
               frame_d = {1'b0, 1'b0, 5'h00, ridx_q, ser_rx};
               go_d = 1'b1;
               st_d = S_SHIFT;
            end else if (reload_q && ridx_q != `TRIM_LAST) begin
               st_d = S_NEXT;
            end else begin
               trim_d = 1'b0;
               reload_d = 1'b0;
               st_d = S_IDLE;
            end
         end
         S_NEXT: begin
            ridx_d = ridx_q + 3'h1;
            rd_dir_d = 1'b1;
            eesel_d = 1'b1;
            frame_d = {1'b1, 1'b1, 5'h00, ridx_q + 3'h1, 8'h00};
            go_d = 1'b1;
            st_d = S_SHIFT;
         end
         default: st_d = S_IDLE;
      endcase
   end
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         st_q <= S_IDLE;
         cdat_q <= 8'h00;
         cadr_q <= 8'h00;
         key_q <= 1'b0;
         mux_q <= 1'b0;
         rd_dir_q <= 1'b0;
         trim_q <= 1'b0;
         reload_q <= 1'b0;
         eesel_q <= 1'b0;
         tdsel_q <= 1'b0;
         ridx_q <= 3'h0;
         go_q <= 1'b0;
         frame_q <= 18'h00000;
      end else if (clk_en) begin
         st_q <= st_d;
         cdat_q <= cdat_d;
         cadr_q <= cadr_d;
         key_q <= key_d;
         mux_q <= mux_d;
         rd_dir_q <= rd_dir_d;
         trim_q <= trim_d;
         reload_q <= reload_d;
         eesel_q <= eesel_d;
         tdsel_q <= tdsel_d;
         ridx_q <= ridx_d;
         go_q <= go_d;
         frame_q <= frame_d;
      end
   end
   cal_serial u_ser (
      .ref_clk (ref_clk),
      .nrst    (nrst),
      .clk_en  (clk_en),
      .start   (go_q),
      .frame   (frame_q),
      .sdi     (cal_sdi),
      .busy    (ser_busy),
      .done    (ser_done),
      .sclk    (cal_sclk),
      .sdo     (cal_sdo),
      .rx      (ser_rx)
   );
   ////////////////////////////////////////////////////////////////////////////
   // Read data, registered on the read event
   logic [7:0] text_rom [0:31];
   localparam logic [247:0] TEXT = "(c) DAQ logic core, all rights.";
   genvar gi;
   generate
      for (gi = 1; gi < 32; gi++) begin : g_text
         assign text_rom[gi] = TEXT[(31 - gi) * 8 +: 8];
      end
   endgenerate
   assign text_rom[0] = 8'h00;
   logic [7:0] rd_q, rd_d;
   logic       busy_any;
   assign busy_any = (st_q != S_IDLE) || ser_busy;
   always_comb begin
      rd_d = rd_q;
      if (rd_go) begin
         rd_d = 8'h00;
         case (page_q)
            `PG_EXT: begin
               case (addr)
                  `OFS_CAL_DATA: rd_d = cdat_q;
                  `OFS_CAL_ADDR: rd_d = cadr_q;
                  `OFS_CAL_CTRL: rd_d = {1'b0, busy_any && (trim_q || reload_q),
                     busy_any && !trim_q && !reload_q, mux_q, 4'h0};
                  `OFS_KEY: rd_d = `REV_CODE;
                  default: rd_d = 8'h00;
               endcase
            end
            `PG_ID: begin
               case (addr)
                  `OFS_LOAD_LO: rd_d = `ID_COUNT_IN;
                  `OFS_LOAD_MID: rd_d = {`ID_DEPTH, `ID_COUNT_OUT};
                  `OFS_LOAD_HI: rd_d = `ID_COUNT_PIN;
                  `OFS_PCMD: rd_d = `ID_PWM_CTR;
                  `OFS_CAL_DATA: rd_d = `CHIP_ID_LO;
                  `OFS_CAL_ADDR: rd_d = `CHIP_ID_HI;
                  default: rd_d = 8'h00;
               endcase
            end
            `PG_TEXT: rd_d = text_rom[addr];
            default: rd_d = 8'h00;
         endcase
      end
   end
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         rd_q <= 8'h00;
      end else if (clk_en) begin
         rd_q <= rd_d;
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   assign rdata = rd_q;
   assign storage_sel_n = !eesel_q;
   assign trim_sel_n = !tdsel_q;
   assign acq_reset = arst_q;
   assign page = page_q;
   assign pulse_load_value = load_q;
   assign pulse_sel = psel_q;
   assign pulse_load_period = lp_q;
   assign pulse_load_duty = ld_q;
   assign pulse_slow_clk = slow_q;
   assign pulse_active_level = pol_q;
   // Disabled output rests at the inactive level set by polarity
   assign pulse_output_on = oen_q;
   assign pulse_run = run_q;
   assign reference_mux_on = mux_q;
   assign analog_cfg_init = `ANALOG_CFG_RST;
   assign fifo_thr_init = `FIFO_THR_RST;
endmodule : daq_ext_pages

// ---- verification/daq_ext_pages_properties.sv ----
// Concurrent checks on the paged register bank ports
module daq_ext_checker (
   input  wire logic           ref_clk,
   input  wire logic           nrst,
   input  wire logic           wr_n,
   input  wire logic           cs_n,
   input  wire logic [1:0]     page,
   input  wire logic           storage_sel_n,
   input  wire logic           trim_sel_n,
   input  wire logic           cal_sclk,
   input  wire logic           acq_reset,
   input  wire logic           pulse_load_period,
   input  wire logic           pulse_load_duty,
   input  wire logic [3:0]     pulse_output_on,
   input  wire logic [3:0]     pulse_run,
   input  wire daq_pkg::byte_t analog_cfg_init,
   input  wire logic [10:0]    fifo_thr_init
);
   import daq_pkg::*;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!nrst);
   ////////////////////////////////////////////////////////////////////////////////
   property p_sel_excl;
      !(!storage_sel_n && !trim_sel_n);
   endproperty
   a_sel_excl: assert property (p_sel_excl) else $error("both selects low");
   property p_load_pulse;
      pulse_load_period |=> !pulse_load_period;
   endproperty
   a_load_pulse: assert property (p_load_pulse) else $error("load pulse too long");
   property p_load_one;
      !(pulse_load_period && pulse_load_duty);
   endproperty
   a_load_one: assert property (p_load_one) else $error("two loads at once");
   property p_init_const;
      analog_cfg_init == 8'h04 && fifo_thr_init == 11'h400;
   endproperty
   a_init_const: assert property (p_init_const) else $error("init values wrong");
   property p_rst_pulse;
      acq_reset |=> !acq_reset;
   endproperty
   a_rst_pulse: assert property (p_rst_pulse) else $error("reset pulse too long");
   // Reset pulse only as the result of a host write
   property p_rst_cause;
      acq_reset |-> $past(!wr_n && !cs_n, 2);
   endproperty
   a_rst_cause: assert property (p_rst_cause) else $error("reset without write");
   property p_run_gate;
      (pulse_run & ~pulse_output_on) == 4'h0;
   endproperty
   a_run_gate: assert property (p_run_gate) else $error("run while disabled");
   property p_sclk_sel;
      $rose(cal_sclk) |-> (!storage_sel_n || !trim_sel_n);
   endproperty
   a_sclk_sel: assert property (p_sclk_sel) else $error("clock without select");
   property p_page_wr;
      !$stable(page) |-> $past(!wr_n && !cs_n, 2);
   endproperty
   a_page_wr: assert property (p_page_wr) else $error("page moved unasked");
endmodule : daq_ext_checker
bind daq_ext_pages daq_ext_checker chk (.ref_clk, .nrst, .wr_n, .cs_n, .page, .storage_sel_n,
   .trim_sel_n, .cal_sclk, .acq_reset, .pulse_load_period, .pulse_load_duty,
   .pulse_output_on, .pulse_run, .analog_cfg_init, .fifo_thr_init);

// ---- verification/cal_far_model.sv ----
// Serial calibration storage and trim converters behind the bank
module cal_far_model (
   input  wire logic sclk,
   input  wire logic sdo,
   input  wire logic storage_sel_n,
   input  wire logic trim_sel_n,
   output logic      sdi
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0]  mem [256];
   logic [7:0]  trim [8];
   logic [17:0] sh;
   logic [7:0]  ad;
   logic        rdf;
   int          cnt;
   initial begin
      for (int i = 0; i < 256; i++) mem[i] = 8'h10 + i[7:0];
      sdi = 1'b0;
      cnt = 0;
      rdf = 1'b0;
   end
   always @(negedge storage_sel_n or negedge trim_sel_n) cnt = 0;
   always @(posedge sclk) begin
      if (!storage_sel_n || !trim_sel_n) begin
         sh = {sh[16:0], sdo};
         cnt++;
         if (cnt == 10) begin
            ad = sh[7:0];
            rdf = sh[8];
         end
      end
   end
   // Only storage answers reads; trims are write only
   always @(negedge sclk) begin
      if (!storage_sel_n && rdf && cnt >= 10 && cnt < 18) sdi = mem[ad][17 - cnt];
   end
   // Released line shows the inverse, never a stale bit
   always @(posedge storage_sel_n) begin
      if (cnt == 18 && !sh[16]) mem[sh[15:8]] = sh[7:0];
      sdi = ~sdi;
   end
   always @(posedge trim_sel_n) begin
      if (cnt == 18) trim[sh[10:8]] = sh[7:0];
      sdi = ~sdi;
   end
endmodule : cal_far_model

// ---- verification/tb.sv ----
// Testbench for the paged register bank over its byte port
`include "daq_defs.svh"
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import daq_pkg::*;
   logic ref_clk, nrst, clk_en, wr_n, rd_n, cs_n, cal_sdi, cal_sclk, cal_sdo;
   logic storage_sel_n, trim_sel_n, acq_reset, pulse_load_period, pulse_load_duty;
   logic pulse_slow_clk, reference_mux_on;
   logic [4:0]     addr;
   logic [7:0]     wdata, rdata, q;
   logic [1:0]     page, pulse_sel;
   logic [23:0]    pulse_load_value;
   logic [3:0]     pulse_active_level, pulse_output_on, pulse_run;
   daq_pkg::byte_t analog_cfg_init;
   logic [10:0]    fifo_thr_init;
   logic [15:0]    cid;
   logic [7:0]     idv [6];
   int             n_fail, tests_run, np, nd, nr;
   daq_ext_pages dut (.ref_clk, .nrst, .clk_en, .addr, .wdata, .wr_n, .rd_n, .cs_n, .rdata,
      .cal_sdi, .cal_sclk, .cal_sdo, .storage_sel_n, .trim_sel_n, .acq_reset, .page,
      .pulse_load_value, .pulse_sel, .pulse_load_period, .pulse_load_duty, .pulse_slow_clk,
      .pulse_active_level, .pulse_output_on, .pulse_run, .reference_mux_on,
      .analog_cfg_init, .fifo_thr_init);
   cal_far_model far (.sclk(cal_sclk), .sdo(cal_sdo), .storage_sel_n, .trim_sel_n,
      .sdi(cal_sdi));
   initial begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk) begin
      np += pulse_load_period;
      nd += pulse_load_duty;
      nr += acq_reset;
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic conclude;
      $display("n_fail=%0d tests_run=%0d", n_fail, tests_run);
      if (n_fail == 0 && tests_run > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : conclude
   // Strobe held six cycles so the three-stage sync always sees it
   task automatic acc(input logic w, input logic [4:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      addr <= a;
      wdata <= d;
      cs_n <= 1'b0;
      if (w) wr_n <= 1'b0;
      else rd_n <= 1'b0;
      repeat (6) @(posedge ref_clk);
      q = rdata;
      cs_n <= 1'b1;
      wr_n <= 1'b1;
      rd_n <= 1'b1;
      repeat (5) @(posedge ref_clk);
   endtask : acc
   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      acc(1'b1, a, d);
   endtask : wr
   task automatic rd(input logic [4:0] a);
      acc(1'b0, a, 8'h00);
   endtask : rd
   task automatic chk(input logic [23:0] got, input logic [23:0] exp);
      tests_run++;
      if (got !== exp) begin
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
         n_fail++;
      end
   endtask : chk
   // Poll status only; data and address stay untouched while busy
   task automatic idle;
      for (int i = 0; i < 3000; i++) begin
         rd(5'h1E);
         if (q[6:5] === 2'b00) return;
      end
      n_fail++;
      conclude();
   endtask : idle
   initial begin
      repeat (100000) @(posedge ref_clk);
      n_fail++;
      conclude();
   end
   initial begin
      {nrst, wr_n, rd_n, cs_n, clk_en, addr, wdata} = {4'h7, 1'b1, 5'h00, 8'h00};
      {n_fail, tests_run, np, nd, nr} = '0;
      cid = `CHIP_ID;
      idv = '{`ID_COUNT_IN, {3'b001, `ID_COUNT_OUT}, `ID_COUNT_PIN, `ID_PWM_CTR, cid[7:0],
         cid[15:8]};
      repeat (5) @(posedge ref_clk);
      nrst <= 1'b1;
      chk({page, storage_sel_n, trim_sel_n, pulse_run}, {2'h0, 2'h3, 4'h0});
      wr(5'h00, 8'h02);
      chk(page, 2'h2);
      for (int i = 0; i < 6; i++) begin
         rd(5'd24 + i[4:0]);
         chk(q, idv[i]);
      end
      wr(5'h00, 8'h03);
      for (int i = 1; i < 32; i++) begin
         rd(i[4:0]);
         chk(q >= 8'h20 && q < 8'h7F, 1'b1);
      end
      wr(5'h00, 8'h01);
      rd(5'h1F);
      chk(q, `REV_CODE);
      wr(5'h18, 8'h11);
      wr(5'h19, 8'h22);
      wr(5'h1A, 8'h33);
      wr(5'h1B, 8'h00);
      chk({np[7:0], pulse_load_value}, {8'h01, 24'h332211});
      wr(5'h1B, 8'h01);
      chk({np[3:0], nd[3:0]}, 8'h11);
      wr(5'h1B, 8'hAF);
      chk({pulse_slow_clk, pulse_sel, pulse_active_level[2], pulse_output_on[2], pulse_run[2]},
         6'b110111);
      wr(5'h1B, 8'hA4);
      chk({pulse_slow_clk, pulse_output_on[2], pulse_run[2]}, 3'b000);
      wr(5'h1D, 8'h05);
      wr(5'h1C, 8'h5A);
      wr(5'h1F, 8'hA5);
      wr(5'h1E, 8'h80);
      idle();
      chk(far.mem[5], 8'h5A);
      wr(5'h1D, 8'h06);
      wr(5'h1C, 8'h77);
      wr(5'h1E, 8'h80);
      idle();
      chk(far.mem[6], 8'h16);
      wr(5'h1D, 8'h05);
      wr(5'h1F, 8'hA5);
      wr(5'h1E, 8'hC0);
      idle();
      rd(5'h1C);
      chk(q, 8'h5A);
      wr(5'h1D, 8'hFB);
      wr(5'h1C, 8'h99);
      wr(5'h1F, 8'hA5);
      wr(5'h1E, 8'h88);
      rd(5'h1E);
      chk(q[6:5], 2'b10);
      idle();
      chk({far.trim[3], far.mem[251]}, 16'h990B);
      wr(5'h1E, 8'h20);
      rd(5'h1E);
      chk(q[6], 1'b1);
      idle();
      for (int i = 0; i < 8; i++) chk(far.trim[i], i == 5 ? 8'h5A : 8'h10 + i);
      wr(5'h1E, 8'h10);
      rd(5'h1E);
      chk({q, reference_mux_on}, 9'h021);
      wr(5'h00, 8'h41);
      chk(nr, 1);
      wr(5'h00, 8'h82);
      wr(5'h00, 8'h03);
      chk(page, 2'h2);
      conclude();
   end
endmodule : tb
